// [design/sir_codec_cfg.svh]
// Timing counts, positions and reset values for the infrared pulse codec
`ifndef SIR_CODEC_CFG_SVH
`define SIR_CODEC_CFG_SVH

// Oversampling ticks in one bit cell
`define SIR_CELL_TICKS   16
// Cell count value at which the transmit pulse rises (7th tick)
`define SIR_PULSE_RISE   4'h7
// Cell count value at which the transmit pulse falls (10th tick)
`define SIR_PULSE_FALL   4'hA
// Cell count value at which the receive strobe fires (8th tick)
`define SIR_SAMPLE_TICK  4'h8
// Last count of a recovered zero before it returns high
`define SIR_LOW_LAST     4'hF
// Counter reset value
`define SIR_CNT_RST      4'h0
// Idle level of serial lines and recovered receive bit
`define SIR_LINE_IDLE    1'b1
// Default character bits between start and stop (data plus parity)
`define SIR_CHAR_BITS    8

`endif

// [design/sir_codec_pkg.sv]
// Types and shared helpers of the infrared pulse codec
package sir_codec_pkg;

    // Four-bit position inside a sixteen-tick bit cell
    typedef logic [3:0] cell_cnt_t;

    // Receive bit sampler states
    typedef enum logic [0:0] {
        SMP_IDLE,
        SMP_RUN
    } sampler_e;

    // Advance a cell counter by one tick, wrapping every sixteen
    function automatic cell_cnt_t cell_next(input cell_cnt_t c);
        cell_next = c + 4'h1;
    endfunction : cell_next

endpackage : sir_codec_pkg

// [design/sir_enc_if.sv]
// Carrier between the codec top and its pulse encoder
`timescale 1ns/100ps
interface sir_enc_if;
    logic ce;      // Clock enable, freezes state when low
    logic tick;    // One-cycle oversampling tick
    logic tx_bit;  // Serial transmit bit, high is idle
    logic pulse;   // Formed infrared pulse, registered

    modport enc (input ce, input tick, input tx_bit, output pulse);
    modport ctl (output ce, output tick, output tx_bit, input pulse);
endinterface : sir_enc_if

// [design/sir_infrared_pulse_codec.sv]
// Serial infrared pulse codec: encoder, decoder and receive bit sampler
//
// Contract
// - Codec runs on sixteen-times-baud oversampling ticks
// - One bit: no pulse for whole cell
// - Zero bit: exactly one pulse per cell
// - Start, data, stop bits coded alike
// - Idle transmit bit: output low, counter cleared
// - Pulse rises tick seven, falls tick ten
// - Pulse repeats every cell while bit zero
// - Reset: recovered bit high, counter cleared
// - Receive falling edge lowers bit next tick
// - Recovered zero lasts sixteen ticks, then high
// - No falling edge keeps recovered bit high
// - Sample tick eight, then every sixteen
// - Positive pulses decode on trailing edge
// - Listen enable only in infrared/half-duplex mode
// - Infrared without listen stores no data
`timescale 1ns/100ps
`include "sir_codec_cfg.svh"
module sir_infrared_pulse_codec
#(
    parameter int CHAR_BITS = `SIR_CHAR_BITS  // Bits between start and stop
)
(
    input  wire logic REF_CLK,                 // 40 MHz reference clock
    input  wire logic RST_N,                   // Asynchronous reset, active low
    input  wire logic CLK_EN,                  // Clock enable, freezes all state
    input  wire logic OVERSAMPLE_CLOCK,        // One-cycle tick at 16x baud
    input  wire logic UART_TX_BIT,             // Serial transmit bit from UART
    input  wire logic TX_ACTIVE,               // UART transmitter busy
    input  wire logic INFRARED_MODE_ENABLE,    // Infrared coding selected
    input  wire logic HALF_DUPLEX_LINE_ENABLE, // Half-duplex line mode
    input  wire logic RECEIVER_LISTEN_ENABLE,  // Receive own traffic
    input  wire logic IR_RX,                   // Receive pin, asynchronous
    output logic      IR_TX,                   // Transmit pin to LED driver
    output logic      RX_BIT,                  // Recovered serial receive bit
    output logic      RX_DATA_VALID,           // Pulse: sampled character bit
    output logic      RX_DATA_BIT,             // Value of the sampled bit
    output logic      RX_FRAME_DONE,           // Pulse: stop bit sampled
    output logic      RX_FRAME_ERROR           // Stop bit was zero, held
);
    localparam int IDX_W = $clog2(CHAR_BITS + 2);  // Bit index width
    localparam logic [IDX_W-1:0] STOP_IDX = IDX_W'(CHAR_BITS + 1);

    // Transmit pin register
    logic                     tx_pin_r;   // Registered transmit pin
    logic                     tx_pin_nxt;

    // Receive pin synchroniser and edge history
    logic                     rx_s1_r;    // First stage, read by stage two only
    logic                     rx_s2_r;    // Second stage, safe to use
    logic                     rx_d_r;     // Previous synchronised level
    logic                     rx_s1_nxt;
    logic                     rx_s2_nxt;
    logic                     rx_d_nxt;
    logic                     rx_fall;    // Falling edge seen this cycle

    // Decoder state
    logic                     pend_r;     // Falling edge waiting for a tick
    logic                     dec_bit_r;  // Recovered bit, high when idle
    sir_codec_pkg::cell_cnt_t dec_cnt_r;  // Ticks spent low
    logic                     pend_nxt;
    logic                     dec_bit_nxt;
    sir_codec_pkg::cell_cnt_t dec_cnt_nxt;

    // Sampler state
    sir_codec_pkg::sampler_e  smp_st_r;   // Idle or inside a character
    sir_codec_pkg::cell_cnt_t smp_cnt_r;  // Ticks since start edge, mod 16
    logic [IDX_W-1:0]         smp_idx_r;  // Bit index, zero is start
    logic                     line_d_r;   // Previous receive line level
    logic                     vld_r;
    logic                     dbit_r;
    logic                     done_r;
    logic                     ferr_r;
    logic                     rxbit_r;
    sir_codec_pkg::sampler_e  smp_st_nxt;
    sir_codec_pkg::cell_cnt_t smp_cnt_nxt;
    logic [IDX_W-1:0]         smp_idx_nxt;
    logic                     line_d_nxt;
    logic                     vld_nxt;
    logic                     dbit_nxt;
    logic                     done_nxt;
    logic                     ferr_nxt;
    logic                     rxbit_nxt;

    // Mode decode
    logic                     rx_line;    // Line seen by the sampler
    logic                     store_ok;   // Sampled bits may be handed on
    logic                     line_fall;  // Start edge on the receive line

    sir_enc_if enc_bus ();

    // Encoder sees a forced one outside infrared mode so it stays clear
    assign enc_bus.ce     = CLK_EN;
    assign enc_bus.tick   = OVERSAMPLE_CLOCK;
    assign enc_bus.tx_bit = INFRARED_MODE_ENABLE ? UART_TX_BIT : `SIR_LINE_IDLE;

    // Pulse former for the transmit direction
    sir_pulse_encoder u_enc
    (
        .clk   (REF_CLK),
        .rst_n (RST_N),
        .enc   (enc_bus.enc)
    );

    // Transmit pin: coded pulse in infrared mode, plain bit otherwise.
    // The extra register costs one reference cycle, far below a tick.
    always_comb
    begin
        tx_pin_nxt = INFRARED_MODE_ENABLE ? enc_bus.pulse : UART_TX_BIT;
    end

    // Transmit pin register, low from reset so the LED stays dark
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            tx_pin_r <= 1'b0;
        end
        else if (CLK_EN)
        begin
            tx_pin_r <= tx_pin_nxt;
        end
    end

    // Receive pin synchroniser: two flops before any logic reads it
    always_comb
    begin
        rx_s1_nxt = IR_RX;
        rx_s2_nxt = rx_s1_r;
        rx_d_nxt  = rx_s2_r;
    end

    // Synchroniser registers; idle high so reset shows no edge
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rx_s1_r <= `SIR_LINE_IDLE;
            rx_s2_r <= `SIR_LINE_IDLE;
            rx_d_r  <= `SIR_LINE_IDLE;
        end
        else if (CLK_EN)
        begin
            rx_s1_r <= rx_s1_nxt;
            rx_s2_r <= rx_s2_nxt;
            rx_d_r  <= rx_d_nxt;
        end
    end

    // Only falling edges count; a positive pulse thus decodes at its
    // trailing edge, which is still sixteen ticks from the next one
    assign rx_fall = rx_d_r & ~rx_s2_r;

    // Decoder next state
    always_comb
    begin
        pend_nxt    = pend_r;
        dec_bit_nxt = dec_bit_r;
        dec_cnt_nxt = dec_cnt_r;
        if (OVERSAMPLE_CLOCK)
        begin
            // Edge is consumed at every tick; one arriving now still counts
            pend_nxt = rx_fall;
            if (!dec_bit_r)
            begin
                if (dec_cnt_r == `SIR_LOW_LAST)
                begin
                    // Cell over: a waiting edge starts the next zero at once
                    dec_bit_nxt = ~pend_r;
                    dec_cnt_nxt = `SIR_CNT_RST;
                end
                else
                begin
                    dec_cnt_nxt = sir_codec_pkg::cell_next(dec_cnt_r);
                end
            end
            else if (pend_r)
            begin
                dec_bit_nxt = 1'b0;
                dec_cnt_nxt = `SIR_CNT_RST;
            end
        end
        else if (rx_fall)
        begin
            // Hold the edge until the next tick
            pend_nxt = 1'b1;
        end
        // Without an edge the bit never leaves high
    end

    // Decoder registers
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            pend_r    <= 1'b0;
            dec_bit_r <= `SIR_LINE_IDLE;
            dec_cnt_r <= `SIR_CNT_RST;
        end
        else if (CLK_EN)
        begin
            pend_r    <= pend_nxt;
            dec_bit_r <= dec_bit_nxt;
            dec_cnt_r <= dec_cnt_nxt;
        end
    end

    // Mode decode for the receive side.
    // Listen enable matters only in infrared or half-duplex mode; in
    // half-duplex it mutes the receiver only while transmitting.
    always_comb
    begin
        rx_line  = INFRARED_MODE_ENABLE ? dec_bit_r : rx_s2_r;
        store_ok = 1'b1;
        if (INFRARED_MODE_ENABLE && !RECEIVER_LISTEN_ENABLE)
        begin
            store_ok = 1'b0;
        end
        else if (HALF_DUPLEX_LINE_ENABLE && !RECEIVER_LISTEN_ENABLE && TX_ACTIVE)
        begin
            store_ok = 1'b0;
        end
    end

    assign line_fall = line_d_r & ~rx_line;

    // Sampler next state: strobe at tick eight after the start edge and
    // every sixteen after, so a one-tick glitch between zeros is missed
    always_comb
    begin
        smp_st_nxt  = smp_st_r;
        smp_cnt_nxt = smp_cnt_r;
        smp_idx_nxt = smp_idx_r;
        line_d_nxt  = rx_line;
        vld_nxt     = 1'b0;
        dbit_nxt    = dbit_r;
        done_nxt    = 1'b0;
        ferr_nxt    = ferr_r;
        rxbit_nxt   = rx_line;
        case (smp_st_r)
            sir_codec_pkg::SMP_IDLE:
            begin
                // Start edge synchronises the strobe
                if (line_fall)
                begin
                    smp_st_nxt  = sir_codec_pkg::SMP_RUN;
                    smp_cnt_nxt = `SIR_CNT_RST;
                    smp_idx_nxt = '0;
                end
            end
            sir_codec_pkg::SMP_RUN:
            begin
                if (OVERSAMPLE_CLOCK)
                begin
                    smp_cnt_nxt = sir_codec_pkg::cell_next(smp_cnt_r);
                    if (smp_cnt_nxt == `SIR_SAMPLE_TICK)
                    begin
                        smp_idx_nxt = smp_idx_r + 1'b1;
                        if (smp_idx_r == '0)
                        begin
                            // A start bit that reads high was noise
                            if (rx_line)
                            begin
                                smp_st_nxt = sir_codec_pkg::SMP_IDLE;
                            end
                        end
                        else if (smp_idx_r == STOP_IDX)
                        begin
                            // Stop bit ends the character
                            smp_st_nxt = sir_codec_pkg::SMP_IDLE;
                            done_nxt   = store_ok;
                            if (store_ok)
                            begin
                                ferr_nxt = ~rx_line;
                            end
                        end
                        else
                        begin
                            vld_nxt  = store_ok;
                            dbit_nxt = rx_line;
                        end
                    end
                end
            end
            default:
            begin
                smp_st_nxt = sir_codec_pkg::SMP_IDLE;
            end
        endcase
    end

    // Sampler and output registers
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            smp_st_r  <= sir_codec_pkg::SMP_IDLE;
            smp_cnt_r <= `SIR_CNT_RST;
            smp_idx_r <= '0;
            line_d_r  <= `SIR_LINE_IDLE;
            vld_r     <= 1'b0;
            dbit_r    <= `SIR_LINE_IDLE;
            done_r    <= 1'b0;
            ferr_r    <= 1'b0;
            rxbit_r   <= `SIR_LINE_IDLE;
        end
        else if (CLK_EN)
        begin
            smp_st_r  <= smp_st_nxt;
            smp_cnt_r <= smp_cnt_nxt;
            smp_idx_r <= smp_idx_nxt;
            line_d_r  <= line_d_nxt;
            vld_r     <= vld_nxt;
            dbit_r    <= dbit_nxt;
            done_r    <= done_nxt;
            ferr_r    <= ferr_nxt;
            rxbit_r   <= rxbit_nxt;
        end
    end

    // Outputs straight from flops
    assign IR_TX          = tx_pin_r;
    assign RX_BIT         = rxbit_r;
    assign RX_DATA_VALID  = vld_r;
    assign RX_DATA_BIT    = dbit_r;
    assign RX_FRAME_DONE  = done_r;
    assign RX_FRAME_ERROR = ferr_r;

endmodule : sir_infrared_pulse_codec

// [design/sir_pulse_encoder.sv]
// Infrared pulse encoder: one three-tick pulse per zero bit cell
`timescale 1ns/100ps
`include "sir_codec_cfg.svh"
module sir_pulse_encoder
(
    input  wire logic clk,     // Reference clock
    input  wire logic rst_n,   // Asynchronous reset, active low
    sir_enc_if.enc    enc      // Tick, bit in, pulse out
);
    sir_codec_pkg::cell_cnt_t cnt_r;    // Ticks since the bit went low
    sir_codec_pkg::cell_cnt_t cnt_nxt;  // Next tick count
    logic                     pulse_r;  // Registered pulse
    logic                     pulse_nxt;

    // Next count and pulse level
    always_comb
    begin
        cnt_nxt   = cnt_r;
        pulse_nxt = pulse_r;
        if (enc.tx_bit)
        begin
            // Idle one: counter held clear, output held low
            cnt_nxt   = `SIR_CNT_RST;
            pulse_nxt = 1'b0;
        end
        else if (enc.tick)
        begin
            // Counter wraps at sixteen so the pulse repeats every cell
            cnt_nxt = sir_codec_pkg::cell_next(cnt_r);
            if (cnt_nxt == `SIR_PULSE_RISE)
            begin
                pulse_nxt = 1'b1;
            end
            else if (cnt_nxt == `SIR_PULSE_FALL)
            begin
                pulse_nxt = 1'b0;
            end
        end
    end

    // Registers; reset leaves no pulse in progress
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r   <= `SIR_CNT_RST;
            pulse_r <= 1'b0;
        end
        else if (enc.ce)
        begin
            cnt_r   <= cnt_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign enc.pulse = pulse_r;

endmodule : sir_pulse_encoder

// [tb/sir_codec_asserts.sv]
// Port-level checker of the infrared pulse codec
`timescale 1ns/100ps
module sir_codec_asserts
(
    input wire logic REF_CLK,                // Clock
    input wire logic RST_N,                  // Reset, active low
    input wire logic OVERSAMPLE_CLOCK,       // Tick
    input wire logic UART_TX_BIT,            // Transmit bit
    input wire logic INFRARED_MODE_ENABLE,   // Infrared mode
    input wire logic RECEIVER_LISTEN_ENABLE, // Listen enable
    input wire logic IR_RX,                  // Receive pin
    input wire logic IR_TX,                  // Transmit pin
    input wire logic RX_BIT,                 // Recovered bit
    input wire logic RX_DATA_VALID,          // Bit strobe
    input wire logic RX_FRAME_DONE,          // Stop strobe
    input wire logic RX_FRAME_ERROR          // Stop error
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    logic [7:0] age_r;  // Cycles in infrared mode, saturating
    logic [3:0] zc_r;   // Ticks since transmit bit fell
    logic [3:0] hi_r;   // Ticks while IR_TX high
    logic [7:0] low_r;  // Ticks while RX_BIT low
    logic [3:0] rxf_r;  // Ticks since IR_RX fell, saturating
    logic [4:0] gap_r;  // Ticks since last strobe
    logic       pv_r;   // Last strobe was a data bit
    logic       rxq_r;  // IR_RX one cycle ago
    logic       ir_ok;  // Mode settled, so old state cannot leak in
    assign ir_ok = &age_r;
    // Tick counters rebuilt from the pins, the timing reference
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            {age_r, zc_r, hi_r, low_r} <= 24'h000000;
            {rxf_r, gap_r, pv_r, rxq_r} <= 11'h781;
        end
        else
        begin
            age_r <= INFRARED_MODE_ENABLE ? age_r + 8'(!ir_ok) : 8'h00;
            zc_r  <= UART_TX_BIT ? 4'h0 : zc_r + 4'(OVERSAMPLE_CLOCK);
            hi_r  <= IR_TX ? hi_r + 4'(OVERSAMPLE_CLOCK) : 4'h0;
            low_r <= RX_BIT ? 8'h00 : low_r + 8'(OVERSAMPLE_CLOCK);
            rxq_r <= IR_RX;
            rxf_r <= (rxq_r && !IR_RX) ? 4'h0 : rxf_r + 4'(OVERSAMPLE_CLOCK && rxf_r != 4'hF);
            gap_r <= (RX_DATA_VALID || RX_FRAME_DONE) ? 5'h00 : gap_r + 5'(OVERSAMPLE_CLOCK);
            pv_r  <= RX_DATA_VALID || (pv_r && !RX_FRAME_DONE);
        end
    end
    property p_tx_idle;
        ir_ok && $past(UART_TX_BIT) && $past(UART_TX_BIT, 2) |-> !IR_TX;
    endproperty
    a_tx_idle: assert property (p_tx_idle) else $error("IR_TX high while idle");
    property p_tx_rise;
        ir_ok && $rose(IR_TX) |-> zc_r == 4'h7;
    endproperty
    a_tx_rise: assert property (p_tx_rise) else $error("pulse rise misplaced");
    property p_tx_width;
        ir_ok && $fell(IR_TX) |-> hi_r == 4'h3;
    endproperty
    a_tx_width: assert property (p_tx_width) else $error("pulse width wrong");
    property p_rx_len;
        ir_ok && $rose(RX_BIT) |-> low_r[3:0] == 4'h0 && low_r != 8'h00;
    endproperty
    a_rx_len: assert property (p_rx_len) else $error("recovered zero length");
    property p_rx_cause;
        ir_ok && $fell(RX_BIT) |-> rxf_r inside {4'h1, 4'h2};
    endproperty
    a_rx_cause: assert property (p_rx_cause) else $error("zero without edge");
    property p_mute;
        ir_ok && !RECEIVER_LISTEN_ENABLE && !$past(RECEIVER_LISTEN_ENABLE)
            |-> !RX_DATA_VALID && !RX_FRAME_DONE;
    endproperty
    a_mute: assert property (p_mute) else $error("strobe while muted");
    property p_gap;
        (RX_DATA_VALID || RX_FRAME_DONE) && pv_r |-> gap_r == 5'h10;
    endproperty
    a_gap: assert property (p_gap) else $error("strobe spacing wrong");
    property p_err;
        $changed(RX_FRAME_ERROR) |-> RX_FRAME_DONE;
    endproperty
    a_err: assert property (p_err) else $error("error changed off stop");
endmodule : sir_codec_asserts

bind sir_infrared_pulse_codec sir_codec_asserts i_chk
(
    .REF_CLK(REF_CLK), .RST_N(RST_N), .OVERSAMPLE_CLOCK(OVERSAMPLE_CLOCK),
    .UART_TX_BIT(UART_TX_BIT), .INFRARED_MODE_ENABLE(INFRARED_MODE_ENABLE),
    .RECEIVER_LISTEN_ENABLE(RECEIVER_LISTEN_ENABLE), .IR_RX(IR_RX), .IR_TX(IR_TX),
    .RX_BIT(RX_BIT), .RX_DATA_VALID(RX_DATA_VALID), .RX_FRAME_DONE(RX_FRAME_DONE),
    .RX_FRAME_ERROR(RX_FRAME_ERROR)
);

// [tb/sir_ir_partner.sv]
// Model of the LED driver and photodiode front end
`timescale 1ns/100ps
module sir_ir_partner
#(
    parameter int CELL  = 352, // Clock cycles per bit cell
    parameter int PULSE = 66   // Three ticks, above the minimum light width
)
(
    input  wire logic clk,     // Reference clock
    input  wire logic led_in,  // LED drive
    output logic      pin_out  // Front-end output
);
    int   lit = 0;     // Flashes seen
    logic idle = 1'b1; // Output level with no light
    initial pin_out = 1'b1;
    // One flash per rising drive edge
    always @(posedge led_in)
        lit++;
    // Dark level; low means positive pulses
    task automatic set_idle(input logic v);
        @(negedge clk);
        idle = v;
        pin_out = v;
    endtask : set_idle
    // Send n cells LSB first; plain sends levels instead of pulses
    task automatic send(input logic [9:0] bits, input int n, input logic plain);
        for (int i = 0; i < n; i++)
        begin
            @(negedge clk);
            pin_out = plain ? bits[i] : (bits[i] ? idle : !idle);
            repeat (PULSE) @(negedge clk);
            pin_out = plain ? bits[i] : idle;
            repeat (CELL - PULSE - 1) @(negedge clk);
        end
    endtask : send
endmodule : sir_ir_partner

// [tb/tb_top.sv]
// Self-checking bench of the infrared pulse codec
`timescale 1ns/100ps
module tb_top;
    localparam int TICK = 22;        // Cycles per tick, baud below the limit
    localparam int CB   = 2;         // Short characters keep the run brief
    localparam int CELL = 16 * TICK;
    logic clk = 1'b0, rst_n = 1'b0, tick = 1'b0, txb = 1'b1, txa = 1'b0;
    logic irm = 1'b1, hdx = 1'b0, lsn = 1'b1;
    logic irrx, irtx, rxb, dv, db, fd, fe;
    logic [7:0] got;                 // Collected data bits
    int num_errors = 0;
    int comparisons = 0;
    int tcnt = 0;
    int nv, nd;                      // Valid and done strobes seen
    always #12.5 clk = ~clk;
    // Tick generator, driven on the falling edge
    always @(negedge clk)
    begin
        tcnt <= (tcnt == TICK - 1) ? 0 : tcnt + 1;
        tick <= (tcnt == TICK - 1);
    end
    // Collect strobes mid-cycle, where the registered outputs are settled
    always @(negedge clk)
    begin
        if (dv === 1'b1)
        begin
            got[nv[2:0]] = db;
            nv++;
        end
        if (fd === 1'b1)
            nd++;
    end
    sir_infrared_pulse_codec #(.CHAR_BITS(CB)) i_dut
    (
        .REF_CLK(clk), .RST_N(rst_n), .CLK_EN(1'b1), .OVERSAMPLE_CLOCK(tick),
        .UART_TX_BIT(txb), .TX_ACTIVE(txa), .INFRARED_MODE_ENABLE(irm),
        .HALF_DUPLEX_LINE_ENABLE(hdx), .RECEIVER_LISTEN_ENABLE(lsn), .IR_RX(irrx),
        .IR_TX(irtx), .RX_BIT(rxb), .RX_DATA_VALID(dv), .RX_DATA_BIT(db),
        .RX_FRAME_DONE(fd), .RX_FRAME_ERROR(fe)
    );
    sir_ir_partner #(.CELL(CELL), .PULSE(3 * TICK)) i_partner
    (
        .clk(clk), .led_in(irtx), .pin_out(irrx)
    );
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        if (num_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // Frame: start zero, data LSB first, then stop
    function automatic logic [9:0] frame(input logic [7:0] ch, input logic stop);
        frame = {1'b0, ch, 1'b0} | (10'h3FF << (CB + 2));
        frame[CB + 1] = stop;
    endfunction : frame
    // Reset levels, checked while reset is held
    task automatic t_reset();
        repeat (2) @(negedge clk);
        check("rst_tx", 8'(irtx), 8'h00);
        check("rst_rx", 8'(rxb), 8'h01);
        check("rst_st", 8'({dv, fd, fe}), 8'h00);
        @(negedge clk);
        rst_n = 1'b1;
    endtask : t_reset
    // One flash per zero cell, none per one cell or when idle
    task automatic t_tx(input logic [7:0] ch);
        logic [9:0] fr;
        int l0;
        fr = frame(ch, 1'b1);
        @(negedge clk iff tick);
        for (int i = 0; i < CB + 3; i++)
        begin
            txb = fr[i];
            l0 = i_partner.lit;
            repeat (CELL) @(negedge clk);
            check("flashes", 8'(i_partner.lit - l0), 8'(!fr[i]));
        end
        check("tx_idle", 8'(irtx), 8'h00);
        check("rx_quiet", 8'(rxb), 8'h01);
    endtask : t_tx
    // Receive one frame and judge the strobes
    task automatic t_rx(input logic [7:0] ch, input logic stop, input logic plain, input int vx);
        nv = 0;
        nd = 0;
        got = 8'h00;
        i_partner.send(frame(ch, stop), CB + 2, plain);
        repeat (CELL) @(negedge clk);
        check("bits", got, (vx != 0) ? ch : 8'h00);
        check("valids", 8'(nv), 8'(vx));
        check("dones", 8'(nd), 8'(vx != 0));
        if (vx != 0)
            check("ferr", 8'(fe), 8'(!stop));
    endtask : t_rx
    // Listen enable against mode: ir, half duplex, listen, expect data
    task automatic t_mute();
        logic [3:0] tbl [4] = '{4'b1000, 4'b1011, 4'b0100, 4'b0001};
        for (int k = 0; k < 4; k++)
        begin
            @(negedge clk);
            {irm, hdx, lsn} = tbl[k][3:1];
            txa = 1'b1;
            repeat (CELL) @(negedge clk);
            t_rx(8'h01, 1'b1, !irm, tbl[k][0] ? CB : 0);
        end
        @(negedge clk);
        {irm, hdx, lsn, txa} = 4'b1010;
    endtask : t_mute
    // Plain mode: a short low blip is a false start and yields no strobe
    task automatic t_glitch();
        @(negedge clk);
        irm = 1'b0;
        nv = 0;
        nd = 0;
        repeat (CELL) @(negedge clk);
        i_partner.send(10'h000, 1, 1'b0);
        repeat (4 * CELL) @(negedge clk);
        check("glitch", 8'({nv[3:0], nd[3:0]}), 8'h00);
        @(negedge clk);
        irm = 1'b1;
    endtask : t_glitch
    // Watchdog sized well above the planned run
    initial
    begin
        #2000000;
        num_errors++;
        end_sim();
    end
    initial
    begin
        t_reset();
        for (int c = 0; c < 4; c++)
            t_tx(8'(c));
        for (int c = 0; c < 4; c++)
            t_rx(8'(c), 1'b1, 1'b0, CB);
        t_rx(8'h02, 1'b0, 1'b0, CB);
        t_rx(8'h01, 1'b1, 1'b0, CB);
        t_mute();
        t_glitch();
        i_partner.set_idle(1'b0);
        repeat ((CB + 3) * CELL) @(negedge clk);
        for (int c = 0; c < 4; c++)
            t_rx(8'(c), 1'b1, 1'b0, CB);
        end_sim();
    end
endmodule : tb_top
